// ---- verilog/bwm_top.sv ----
// Breaker wear monitor with its Avalon-MM register slave.
// Contract
// RULE_01 - Interrupted current measured per pole separately.
// RULE_02 - Capture currents when supervised trip output activates.
// RULE_03 - Curve table holds up to eight points.
// RULE_04 - Software fills unused points with oversize current.
// RULE_05 - Log/log interpolation between curve points two-eight.
// RULE_06 - Exponent from segment counts and currents ratio.
// RULE_07 - Segment constant from same segment endpoints.
// RULE_08 - Two alarm levels: current and limit settings.
// RULE_09 - Each pole current weighted against both levels.
// RULE_10 - Above level: decrement is count ratio.
// RULE_11 - Below level: decrement by exactly one.
// RULE_12 - Decrement quotient rounded to nearest whole.
// RULE_13 - Three counters per level; smallest is supervised.
// RULE_14 - Smallest below limit raises level alarm output.
// RULE_15 - Four transition events, each gated by enable.
// RULE_16 - Clear reloads counters with count at level.
// RULE_17 - Record latest trip time and pole currents.
// RULE_18 - Protected settings writable only after authorisation.
`timescale 1ns/10ps
module bwm_top #(
    parameter logic [31:0] AUTH_KEY = 32'h0000c0de // Arbitrary value.
)(
    input  wire logic                       clk,          // 125 MHz clock
    input  wire logic                       rstn,         // Async reset
    input  wire logic [bwm_pkg::ADDR_W-1:0] address,      // Byte address
    input  wire logic                       read,         // Read request
    input  wire logic                       write,        // Write request
    input  wire logic [bwm_pkg::DATA_W-1:0] writedata,    // Write data
    input  wire logic [3:0]                 byteenable,   // Byte lanes
    output logic      [bwm_pkg::DATA_W-1:0] readdata,     // Read data
    output logic                            waitrequest,  // Stall
    input  wire logic                       trip_out,     // Supervised trip
    input  wire logic [bwm_pkg::CUR_W-1:0]  ph1_cur,      // Pole 1 current
    input  wire logic [bwm_pkg::CUR_W-1:0]  ph2_cur,      // Pole 2 current
    input  wire logic [bwm_pkg::CUR_W-1:0]  ph3_cur,      // Pole 3 current
    input  wire logic [31:0]                time_of_day,  // Time stamp
    output logic                            alarm_lvl1,   // Level 1 alarm
    output logic                            alarm_lvl2,   // Level 2 alarm
    output logic                            irq           // Interrupt
);
    import bwm_pkg::*;

    function automatic logic [LOG_W-1:0] log2q(input logic [CNT_W-1:0] x);
        int p;
        logic [CNT_W-1:0] sh;
        p = 0;
        for (int i = 0; i < CNT_W; i++) begin
            if (x[i]) begin
                p = i;
            end
        end
        sh = x << (CNT_W - 1 - p);
        return {5'(p), sh[CNT_W-2 -: LOG_FW]};
    endfunction

    // Piecewise linear 2^q, rounded to the nearest whole count.
    function automatic logic [CNT_W-1:0] exp2q(input logic [LOG_W-1:0] q);
        logic [31:0] v;
        v = 32'({1'b1, q[LOG_FW-1:0]}) << q[LOG_W-1:LOG_FW];
        v = (v + ROUND_HALF) >> LOG_FW;
        if (q[LOG_W-1:LOG_FW] >= 5'(CNT_W) || v > 32'({CNT_W{1'b1}})) begin
            return {CNT_W{1'b1}};
        end
        return v[CNT_W-1:0];
    endfunction

    logic [1:0] rst_sync_q;
    logic       rst_n_s;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n_s = rst_sync_q[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_s);

    // Bus slave: one wait cycle, then the request completes.
    logic              wait_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              req;
    logic              take;
    logic              wr_ok;
    logic              prot_ok;
    logic              auth_q;
    assign req     = read | write;
    assign take    = req & ~wait_q;
    assign wr_ok   = take & write & (byteenable == BE_FULL);
    assign prot_ok = wr_ok & auth_q;
    assign readdata    = rdata_q;
    assign waitrequest = wait_q;

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            wait_q <= ~(req & wait_q);
            if (read & wait_q) begin
                rdata_q <= rdata_d;
            end
        end
    end
    a_bus_wait: assert property ((req && wait_q) |=> !wait_q ##1 wait_q)
        else $error("bus answer not after exactly one wait cycle");

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            auth_q <= 1'b0;
        end else if (wr_ok && address == OFS_AUTH) begin
            auth_q <= (writedata == AUTH_KEY); // RULE_18
        end
    end

    // Settings.
    logic [CUR_W-1:0] crv_cur_q [NPTS];
    logic [CNT_W-1:0] crv_cnt_q [NPTS];
    logic [CUR_W-1:0] lvl_cur_q [NLVL];
    logic [CNT_W-1:0] lvl_lim_q [NLVL];
    logic [EVT_W-1:0] evt_en_q;
    logic [EVT_W-1:0] int_en_q;
    logic             clr_cmd;
    assign clr_cmd = prot_ok && address == OFS_CTRL
                     && writedata[CTRL_CLEAR_BIT]; // RULE_18

    // Reset loads every point with an oversize current (RST_CRV_CUR), so unused points need no write.
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            for (int i = 0; i < NPTS; i++) begin
                crv_cur_q[i] <= RST_CRV_CUR;
                crv_cnt_q[i] <= RST_CRV_CNT;
            end
        end else begin
            for (int i = 0; i < NPTS; i++) begin // RULE_03
                if (wr_ok && address == 8'(OFS_CRV_CUR + WORD_BYTES * i)) begin
                    crv_cur_q[i] <= writedata[CUR_W-1:0];
                end
                if (wr_ok && address == 8'(OFS_CRV_CNT + WORD_BYTES * i)) begin
                    crv_cnt_q[i] <= writedata[CNT_W-1:0];
                end
            end
        end
    end

    // Levels are clamped to their settable ranges.
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            for (int l = 0; l < NLVL; l++) begin
                lvl_cur_q[l] <= '0;
                lvl_lim_q[l] <= LIM_MIN;
            end
            evt_en_q <= '0;
        end else begin
            for (int l = 0; l < NLVL; l++) begin // RULE_08
                if (prot_ok && address == 8'(OFS_LVL_CUR + LVL_STRIDE * l))
                begin
                    lvl_cur_q[l] <= (writedata > 32'(CUR_MAX)) ? CUR_MAX
                                    : writedata[CUR_W-1:0];
                end
                if (prot_ok && address == 8'(OFS_LVL_LIM + LVL_STRIDE * l))
                begin
                    lvl_lim_q[l] <= (writedata > 32'(LIM_MAX)) ? LIM_MAX
                                  : (writedata < 32'(LIM_MIN)) ? LIM_MIN
                                  : writedata[CNT_W-1:0];
                end
            end
            if (prot_ok && address == OFS_EVT_EN) begin
                evt_en_q <= writedata[EVT_W-1:0];
            end
        end
    end
    a_auth_guard: assert property ((take && write && !auth_q) // RULE_18
        |=> $stable(lvl_cur_q[0]) && $stable(lvl_lim_q[1])
            && $stable(evt_en_q))
        else $error("protected setting changed without authorisation");

    // Trip capture and latest-trip record.
    logic             trip_prev_q;
    logic             trip_rise;
    logic [31:0]      trip_time_q;
    logic [CUR_W-1:0] trip_cur_q [NPH];
    assign trip_rise = trip_out & ~trip_prev_q; // RULE_02
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            trip_prev_q <= 1'b0;
            trip_time_q <= '0;
            for (int p = 0; p < NPH; p++) begin
                trip_cur_q[p] <= '0;
            end
        end else begin
            trip_prev_q <= trip_out;
            if (trip_rise) begin
                trip_time_q   <= time_of_day; // RULE_17
                trip_cur_q[0] <= ph1_cur;     // RULE_01
                trip_cur_q[1] <= ph2_cur;
                trip_cur_q[2] <= ph3_cur;
            end
        end
    end
    a_trip_record: assert property (trip_rise |=> trip_cur_q[1] // RULE_17
        == $past(ph2_cur) && trip_time_q == $past(time_of_day))
        else $error("trip record not captured at trip rise");

    // Wear engine: log2 of the permitted count for five currents on a trip, two on a clear.
    bwm_state_e       st_q;
    logic             pend_clr_q;
    logic             pend_trip_q;
    logic             job_clr_q;
    logic [2:0]       ev_q;
    logic [CUR_W-1:0] job_cur_q [NPH];
    logic [LOG_W-1:0] lc_q [NEVAL];
    logic [LOG_W-1:0] base_q;
    logic [LOG_W-1:0] dc_q;
    logic [PROD_W-1:0] num_q;
    logic [PROD_W-1:0] quo_q;
    logic [LOG_W-1:0] den_q;
    logic [LOG_W-1:0] rem_q;
    logic [4:0]       bit_q;
    logic [LOG_W-1:0] lcur [NPTS];
    logic [LOG_W-1:0] lcnt [NPTS];
    logic [CUR_W-1:0] ev_x;
    logic [LOG_W-1:0] s_base;
    logic [LOG_W-1:0] s_dc;
    logic [LOG_W-1:0] s_dx;
    logic [LOG_W-1:0] s_di;
    logic [LOG_W:0]   dv_t;
    logic             dv_ge;
    logic [LOG_W-1:0] q_clamp;
    logic             ev_last;

    for (genvar i = 0; i < NPTS; i++) begin : g_log
        assign lcur[i] = log2q(CNT_W'(crv_cur_q[i]));
        assign lcnt[i] = log2q(crv_cnt_q[i]);
    end

    assign ev_x = (ev_q < 3'(NLVL)) ? lvl_cur_q[ev_q[0]]
                : job_cur_q[2'(ev_q - 3'(NLVL))];

    // log C = log C_k - n * (log I - log I_k), with n from the segment.
    always_comb begin
        logic [2:0] seg;
        seg = 3'(SEG_FIRST);
        for (int k = SEG_FIRST; k <= SEG_LAST; k++) begin // RULE_05
            if (ev_x >= crv_cur_q[k]) begin
                seg = 3'(k);
            end
        end
        s_base = lcnt[seg];
        s_dc   = (lcnt[seg] > lcnt[3'(seg + 3'h1)])
                 ? lcnt[seg] - lcnt[3'(seg + 3'h1)] : '0; // RULE_06
        s_di   = lcur[3'(seg + 3'h1)] - lcur[seg];        // RULE_07
        s_dx   = log2q(CNT_W'(ev_x)) - lcur[seg];
        if (ev_x < crv_cur_q[SEG_FIRST]) begin
            s_dc = '0;
        end
        if (ev_x >= crv_cur_q[SEG_LAST + 1]) begin
            s_base = lcnt[SEG_LAST + 1];
            s_dc   = '0;
        end
    end

    assign dv_t    = {rem_q, num_q[PROD_W-1]};
    assign dv_ge   = dv_t >= {1'b0, den_q};
    assign q_clamp = (quo_q > PROD_W'(dc_q)) ? dc_q : quo_q[LOG_W-1:0];
    assign ev_last = job_clr_q ? (ev_q == 3'(NLVL - 1))
                               : (ev_q == 3'(NEVAL - 1));

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pend_clr_q  <= 1'b0;
            pend_trip_q <= 1'b0;
        end else begin
            pend_clr_q  <= (pend_clr_q & ~(st_q == ST_IDLE)) | clr_cmd;
            pend_trip_q <= (pend_trip_q & ~(st_q == ST_IDLE && !pend_clr_q))
                           | trip_rise;
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            st_q      <= ST_IDLE;
            job_clr_q <= 1'b0;
            ev_q      <= '0;
            base_q    <= '0;
            dc_q      <= '0;
            num_q     <= '0;
            quo_q     <= '0;
            den_q     <= '0;
            rem_q     <= '0;
            bit_q     <= '0;
            for (int e = 0; e < NEVAL; e++) begin
                lc_q[e] <= '0;
            end
            for (int p = 0; p < NPH; p++) begin
                job_cur_q[p] <= '0;
            end
        end else begin
            case (st_q)
                ST_IDLE: begin
                    ev_q <= '0;
                    if (pend_clr_q) begin
                        job_clr_q <= 1'b1;
                        st_q      <= ST_SETUP;
                    end else if (pend_trip_q) begin
                        job_clr_q <= 1'b0;
                        job_cur_q <= trip_cur_q;
                        st_q      <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    base_q <= s_base;
                    dc_q   <= s_dc;
                    num_q  <= s_dc * (s_dx > s_di ? s_di : s_dx);
                    den_q  <= s_di;
                    rem_q  <= '0;
                    quo_q  <= '0;
                    bit_q  <= 5'(PROD_W);
                    st_q   <= ST_DIV;
                end
                ST_DIV: begin
                    if (bit_q != 5'h0) begin
                        num_q <= num_q << 1;
                        quo_q <= {quo_q[PROD_W-2:0], dv_ge};
                        rem_q <= dv_ge ? LOG_W'(dv_t - {1'b0, den_q})
                                       : LOG_W'(dv_t);
                        bit_q <= bit_q - 5'h1;
                    end else begin
                        lc_q[ev_q] <= base_q - q_clamp;
                        ev_q       <= ev_q + 3'h1;
                        st_q       <= ev_last ? ST_APPLY : ST_SETUP;
                    end
                end
                ST_APPLY: begin
                    st_q <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end
    a_job_bounded: assert property ((st_q == ST_IDLE && pend_trip_q) // RULE_09
        |-> ##[1:160] st_q == ST_APPLY)
        else $error("wear job did not finish in time");

    // Operations-left counters, level-major: index = level * 3 + pole.
    logic [CNT_W-1:0] ops_q [NCTR];
    for (genvar g = 0; g < NCTR; g++) begin : g_ctr
        localparam int L = g / NPH;
        localparam int P = g % NPH;
        logic [LOG_W-1:0] diff;
        logic [CNT_W-1:0] delta;
        logic             above;
        assign above = job_cur_q[P] > lvl_cur_q[L]; // RULE_09
        assign diff  = (lc_q[L] > lc_q[NLVL + P])
                       ? lc_q[L] - lc_q[NLVL + P] : '0;
        // Ratio of counts is 2 to the power of the difference of their logs.
        assign delta = above ? exp2q(diff) : DEC_UNIT; // RULE_10 RULE_11 RULE_12
        always_ff @(posedge clk or negedge rst_n_s) begin
            if (!rst_n_s) begin
                ops_q[g] <= '0;
            end else if (st_q == ST_APPLY) begin
                if (job_clr_q) begin
                    ops_q[g] <= exp2q(lc_q[L]); // RULE_16
                end else begin
                    ops_q[g] <= (ops_q[g] > delta) ? ops_q[g] - delta : '0;
                end
            end
        end
        a_below_one: assert property ((st_q == ST_APPLY // RULE_11
            && !job_clr_q && !above && ops_q[g] != '0) |=> ops_q[g]
            == $past(ops_q[g]) - DEC_UNIT)
            else $error("counter below level not reduced by one");
        a_no_rise: assert property ((st_q != ST_APPLY || !job_clr_q) // RULE_13
            |=> ops_q[g] <= $past(ops_q[g]))
            else $error("counter rose without a clear");
    end

    // Smallest of the three counters per level against its limit.
    logic [NLVL-1:0] alarm_q;
    logic [NLVL-1:0] alarm_d;
    always_comb begin
        for (int l = 0; l < NLVL; l++) begin
            logic [CNT_W-1:0] m;
            m = ops_q[l * NPH];
            for (int p = 1; p < NPH; p++) begin // RULE_13
                if (ops_q[l * NPH + p] < m) begin
                    m = ops_q[l * NPH + p];
                end
            end
            alarm_d[l] = m < lvl_lim_q[l]; // RULE_14
        end
    end
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            alarm_q <= '0;
        end else begin
            alarm_q <= alarm_d;
        end
    end
    assign alarm_lvl1 = alarm_q[0];
    assign alarm_lvl2 = alarm_q[1];
    a_alarm_min: assert property ((ops_q[3] < lvl_lim_q[1] // RULE_14
        && ops_q[4] < lvl_lim_q[1] && ops_q[5] < lvl_lim_q[1])
        |=> alarm_lvl2)
        else $error("level 2 alarm missing with all counters low");

    // Events and interrupt; a new event wins over a clear.
    logic [EVT_W-1:0] status_q;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic             irq_q;
    assign evt_set = evt_en_q & {alarm_q[1] & ~alarm_d[1],
                                 ~alarm_q[1] & alarm_d[1],
                                 alarm_q[0] & ~alarm_d[0],
                                 ~alarm_q[0] & alarm_d[0]}; // RULE_15
    assign evt_clr = (wr_ok && address == OFS_INT_CLR)
                     ? writedata[EVT_W-1:0] : '0;
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            status_q <= '0;
            int_en_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            status_q <= (status_q & ~evt_clr) | evt_set;
            irq_q    <= |(status_q & int_en_q);
            if (wr_ok && address == OFS_INT_EN) begin
                int_en_q <= writedata[EVT_W-1:0];
            end
        end
    end
    assign irq = irq_q;
    a_evt_gate: assert property ((!status_q[EVT_L1_ON] // RULE_15
        && !evt_en_q[EVT_L1_ON]) |=> !status_q[EVT_L1_ON])
        else $error("disabled event was recorded");
    a_evt_set: assert property ((alarm_d[1] && !alarm_q[1] // RULE_15
        && evt_en_q[EVT_L2_ON]) |=> status_q[EVT_L2_ON]
        ##1 (irq || !int_en_q[EVT_L2_ON]))
        else $error("enabled alarm event not recorded");

    c_trip_job: cover property (st_q == ST_APPLY && !job_clr_q);
    c_clear_job: cover property (st_q == ST_APPLY && job_clr_q);
    c_alarm1: cover property (!alarm_lvl1 ##1 alarm_lvl1);
    c_irq: cover property (irq);

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        rdata_d = '0;
        case (address)
            OFS_AUTH:      rdata_d = 32'(auth_q);
            OFS_CTRL:      rdata_d = 32'(st_q != ST_IDLE);
            OFS_EVT_EN:    rdata_d = 32'(evt_en_q);
            OFS_STATUS:    rdata_d = 32'(status_q);
            OFS_INT_EN:    rdata_d = 32'(int_en_q);
            OFS_ALARM:     rdata_d = 32'(alarm_q);
            OFS_TRIP_TIME: rdata_d = trip_time_q;
            default:       rdata_d = '0;
        endcase
        for (int l = 0; l < NLVL; l++) begin
            if (address == 8'(OFS_LVL_CUR + LVL_STRIDE * l)) begin
                rdata_d = 32'(lvl_cur_q[l]);
            end
            if (address == 8'(OFS_LVL_LIM + LVL_STRIDE * l)) begin
                rdata_d = 32'(lvl_lim_q[l]);
            end
        end
        for (int p = 0; p < NPH; p++) begin
            if (address == 8'(OFS_TRIP_CUR + WORD_BYTES * p)) begin
                rdata_d = 32'(trip_cur_q[p]);
            end
        end
        for (int c = 0; c < NCTR; c++) begin
            if (address == 8'(OFS_OPS + WORD_BYTES * c)) begin
                rdata_d = 32'(ops_q[c]);
            end
        end
        for (int i = 0; i < NPTS; i++) begin
            if (address == 8'(OFS_CRV_CUR + WORD_BYTES * i)) begin
                rdata_d = 32'(crv_cur_q[i]);
            end
            if (address == 8'(OFS_CRV_CNT + WORD_BYTES * i)) begin
                rdata_d = 32'(crv_cnt_q[i]);
            end
        end
    end
endmodule

// ---- verilog/bwm_pkg.sv ----
// Shared constants, register map and state type of the breaker wear monitor.
package bwm_pkg;
    localparam int CUR_W   = 16;           // Current in units of 10 A.
    localparam int CNT_W   = 17;           // Operation counts.
    localparam int NPTS    = 8;            // Breaker curve points.
    localparam int NPH     = 3;            // Poles.
    localparam int NLVL    = 2;            // Alarm levels.
    localparam int NCTR    = NLVL * NPH;   // Operations-left counters.
    localparam int NEVAL   = NLVL + NPH;   // Log evaluations of a trip job.
    localparam int LOG_FW  = 8;            // Fraction bits of log2 values.
    localparam int LOG_W   = 13;           // 5 integer bits and fraction.
    localparam int PROD_W  = 2 * LOG_W;    // Divider numerator width.
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int EVT_W   = 4;
    localparam int SEG_FIRST = 1;          // Curve point 2 as an index.
    localparam int SEG_LAST  = 6;          // Curve point 7 as an index.

    localparam logic [ADDR_W-1:0] OFS_AUTH      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_EVT_EN    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LVL_CUR   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_LVL_LIM   = 8'h10;
    localparam logic [ADDR_W-1:0] LVL_STRIDE    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_INT_CLR   = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_INT_EN    = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_ALARM     = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_TRIP_TIME = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_TRIP_CUR  = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_OPS       = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_CRV_CUR   = 8'h60;
    localparam logic [ADDR_W-1:0] OFS_CRV_CNT   = 8'h80;
    localparam logic [ADDR_W-1:0] WORD_BYTES    = 8'h04;

    localparam int CTRL_CLEAR_BIT = 0;
    localparam int EVT_L1_ON  = 0;
    localparam int EVT_L1_OFF = 1;
    localparam int EVT_L2_ON  = 2;
    localparam int EVT_L2_OFF = 3;

    localparam logic [CUR_W-1:0] CUR_MAX     = 16'h2710;  // 100.00 kA.
    localparam logic [CNT_W-1:0] LIM_MAX     = 17'h186a0; // 100000.
    localparam logic [CNT_W-1:0] LIM_MIN     = 17'h00001;
    localparam logic [CUR_W-1:0] RST_CRV_CUR = 16'hffff;
    localparam logic [CNT_W-1:0] RST_CRV_CNT = 17'h00001;
    localparam logic [CNT_W-1:0] DEC_UNIT    = 17'h00001;
    localparam logic [31:0]      ROUND_HALF  = 32'h00000080;
    localparam logic [3:0]       BE_FULL     = 4'hf;

    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_DIV, ST_APPLY}
        bwm_state_e;
endpackage

// ---- verif/bwm_feed.sv ----
// Trip relay and pole current source facing the monitor.
`timescale 1ns/10ps
module bwm_feed (
    input  wire logic        clk,  // Bench clock
    output logic             trip, // Supervised trip
    output logic [15:0]      c1,   // Pole 1 current
    output logic [15:0]      c2,   // Pole 2 current
    output logic [15:0]      c3,   // Pole 3 current
    output logic [31:0]      tod   // Time stamp
);
    initial begin
        trip = 1'b0;
        {c1, c2, c3, tod} = '0;
    end
    // Currents change after the trip so that a late capture shows.
    task automatic fire(logic [15:0] a, b, c, logic [31:0] t);
        @(posedge clk);
        {c1, c2, c3, tod} <= {a, b, c, t};
        trip <= 1'b1;
        repeat (4) @(posedge clk);
        trip <= 1'b0;
        {c1, c2, c3, tod} <= ~{a, b, c, t};
    endtask
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench of the breaker wear monitor.
`timescale 1ns/10ps
module testbench;
    import bwm_pkg::*;
    logic        clk, rstn, rd, wr, wq, trip, a1, a2, irq;
    logic [7:0]  adr;
    logic [31:0] wd, rdat, tod, v;
    logic [15:0] p1, p2, p3;
    int          err_count = 0, checks_done = 0, cyc = 0, ex[6];
    int          dx[6], got[6];
    bwm_top dut (.clk(clk), .rstn(rstn), .address(adr), .read(rd),
        .write(wr), .writedata(wd), .byteenable(4'hf), .readdata(rdat),
        .waitrequest(wq), .trip_out(trip), .ph1_cur(p1), .ph2_cur(p2),
        .ph3_cur(p3), .time_of_day(tod), .alarm_lvl1(a1),
        .alarm_lvl2(a2), .irq(irq));
    bwm_feed feed (.clk(clk), .trip(trip), .c1(p1), .c2(p2), .c3(p3),
        .tod(tod));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            close_out;
        end
    end
    function automatic real perm(int i);
        real n;
        n = $ln(125.0) / $ln(24.8);
        return i <= 125 ? 10000.0 : 10000.0 * (125.0 / i) ** n;
    endfunction
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        {rd, wr, adr, wd} <= {!w, w, a, d};
        do @(posedge clk); while (wq !== 1'b0);
        v = rdat;
        {rd, wr} <= 2'b00;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %0h got %0h", n, e, g);
        end
    endtask
    task automatic near(string n, int e, logic [31:0] g);
        checks_done++;
        if ($isunknown(g) || (int'(g) - e) ** 2 > (e / 25 + 3) ** 2) begin
            err_count++;
            $display("BAD %s exp %0d got %0d", n, e, g);
        end
    endtask
    task automatic rc(string n, logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, v);
    endtask
    task automatic settle(bit step);
        repeat (2) @(posedge clk);
        do bus(1'b0, OFS_CTRL, 32'h0);
        while (v[0] !== 1'b0);
        for (int k = 0; k < 6; k++) begin
            bus(1'b0, OFS_OPS + 8'(4 * k), 32'h0);
            near("ops left", ex[k], v);
            if (step) chk("ops step", got[k] - dx[k], v);
            got[k] = v;
        end
    endtask
    task automatic trip_job(logic [15:0] a, b, c, bit step);
        logic [31:0] t;
        int          lv;
        t = $urandom;
        feed.fire(a, b, c, t);
        rc("trip time", OFS_TRIP_TIME, t);
        rc("trip cur 1", OFS_TRIP_CUR, a);
        rc("trip cur 2", OFS_TRIP_CUR + 8'h4, b);
        rc("trip cur 3", OFS_TRIP_CUR + 8'h8, c);
        for (int k = 0; k < 6; k++) begin
            lv = k < 3 ? 125 : 600;
            t = k % 3 == 0 ? a : k % 3 == 1 ? b : c;
            dx[k] = int'(t) <= lv ? 1 : int'(perm(lv) / perm(t));
            ex[k] -= dx[k];
        end
        settle(step);
        $display("end of trip test");
    endtask
    initial begin
        rstn = 1'b0;
        {rd, wr, adr, wd} = '0;
        void'($urandom(32'hee94));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b1, OFS_LVL_LIM, 32'h5);
        rc("locked limit", OFS_LVL_LIM, 32'h1);
        bus(1'b1, OFS_AUTH, 32'h0000c0de);
        bus(1'b1, OFS_LVL_LIM, 32'h30d40);
        rc("limit clamp", OFS_LVL_LIM, 32'h186a0);
        bus(1'b1, OFS_LVL_LIM, 32'h1);
        for (int k = 1; k < 8; k++) begin
            bus(1'b1, OFS_CRV_CUR + 8'(4 * k),
                k == 1 ? 125 : k == 2 ? 3100 : 10000);
            bus(1'b1, OFS_CRV_CNT + 8'(4 * k),
                k == 1 ? 10000 : k == 2 ? 80 : 1);
        end
        bus(1'b1, OFS_LVL_CUR, 32'd125);
        bus(1'b1, OFS_LVL_CUR + LVL_STRIDE, 32'd600);
        bus(1'b1, OFS_EVT_EN, 32'hf);
        bus(1'b1, OFS_INT_EN, 32'hf);
        bus(1'b1, OFS_CTRL, 32'h1);
        ex = '{10000, 10000, 10000, 945, 945, 945};
        settle(1'b0);
        rc("release events", OFS_STATUS, 32'ha);
        chk("irq set", 1'b1, irq);
        bus(1'b1, OFS_INT_CLR, 32'hf);
        rc("status clear", OFS_STATUS, 32'h0);
        chk("irq clear", 1'b0, irq);
        $display("end of clear test");
        trip_job(16'd1250, 16'd1250, 16'd150, 1'b1);
        trip_job(16'($urandom_range(3100, 1)), 16'($urandom_range(3100, 1)),
            16'($urandom_range(3100, 1)), 1'b0);
        bus(1'b1, OFS_INT_EN, 32'h4);
        bus(1'b1, OFS_LVL_LIM + LVL_STRIDE, 32'd10000);
        rc("alarm reg", OFS_ALARM, 32'h2);
        chk("alarm 2 pin", 1'b1, a2);
        chk("alarm 1 pin", 1'b0, a1);
        rc("assert event", OFS_STATUS, 32'h4);
        chk("irq on", 1'b1, irq);
        bus(1'b1, OFS_EVT_EN, 32'h0);
        bus(1'b1, OFS_INT_CLR, 32'hf);
        bus(1'b1, OFS_LVL_LIM + LVL_STRIDE, 32'h1);
        rc("gated event", OFS_STATUS, 32'h0);
        chk("alarm 2 off", 1'b0, a2);
        chk("irq off", 1'b0, irq);
        $display("end of alarm test");
        close_out;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
endmodule
